//--- shared/ssst_consts.vh
/*
  Constants of the synchronous-slave serial transmit path: character sizes,
  reset values, buffer shape and link clock figures.
  Assumes inclusion by its bare name from the design files.
*/
`ifndef SSST_CONSTS_VH
`define SSST_CONSTS_VH

// ************************************************************
// character format
// ************************************************************
`define SSST_BITS_8 4'h8
`define SSST_BITS_9 4'h9
`define SSST_CHAR_W 9
`define SSST_CNT_W 4

// ************************************************************
// buffer shape
// ************************************************************
`define SSST_FIFO_DEPTH 8
`define SSST_FIFO_AW 3

// ************************************************************
// reset values
// ************************************************************
`define SSST_RST_DATA 1'h1
`define SSST_RST_OE 1'h0
`define SSST_RST_FLAG 1'h0
`define SSST_RST_CHAR 9'h000
`define SSST_RST_CNT 4'h0

// ************************************************************
// clock figures: design clock and master's shift clock periods in ns, and their ratio
// ************************************************************
`define SSST_CLK_NS 40
`define SSST_LINK_NS 320
`define SSST_LINK_CYC (`SSST_LINK_NS / `SSST_CLK_NS)

`endif

//--- src/ssst_top.v
/*
  Transmit path of a serial port in synchronous slave mode: a character FIFO,
  the holding register, the shift register and the ready, wake and interrupt
  outputs. Assumes an external master that toggles the shift clock pin far
  slower than clock (at least four clock periods per half period) and
  configuration bits that come from logic on clock.
*/
// Behaviour
// - sync-mode select 1 means synchronous operation
// - clock source 0: slave, clock from pin
// - both receive enables 0 means transmit mode
// - port works only while port enable set
// - slave transmit equals master, clock aside
// - sleep with two words: first shifts immediately
// - second word waits, ready flag stays clear
// - after first shifts, move second, set flag
// - enabled flag wakes; global enable enters handler
// - nine-bit select sends ninth bit as msb
// - transmission only while transmit enable set
// - writing low byte starts the character
`timescale 1ns/1ns
`default_nettype none
`include "ssst_consts.vh"

// ************************************************************
// character FIFO
// ************************************************************
module ssst_fifo #(
  parameter WIDTH = `SSST_CHAR_W,
  parameter DEPTH = `SSST_FIFO_DEPTH,
  parameter AW = `SSST_FIFO_AW
) (
  // clock and reset
  input wire clock,
  input wire sys_rst,
  // fill side
  input wire in_valid,
  output reg in_ready,
  input wire [WIDTH-1:0] in_data,
  // drain side
  output reg out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  localparam [AW:0] DEPTH_W = DEPTH;
  localparam [AW:0] ONE_W = 1;
  localparam [AW-1:0] STEP = 1;

  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_q;
  reg [AW-1:0] rd_ptr_q;
  reg [AW:0] count_q;
  reg [AW:0] count_d;
  wire push;
  wire pop;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem_q[rd_ptr_q];

  always @*
  begin
    count_d = count_q;
    if (push & ~pop)
    begin
      count_d = count_q + ONE_W;
    end
    else if (pop & ~push)
    begin
      count_d = count_q - ONE_W;
    end
  end

  // depth is a power of two, so the pointers wrap by themselves
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_q <= wr_ptr_q + STEP;
      end
      if (pop)
      begin
        rd_ptr_q <= rd_ptr_q + STEP;
      end
      count_q <= count_d;
      in_ready <= (count_d != DEPTH_W);
      out_valid <= (count_d != {(AW+1){1'b0}});
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi = gi + 1)
    begin : g_entry
      always @(posedge clock)
      begin
        if (push && (wr_ptr_q == gi))
        begin
          mem_q[gi] <= in_data;
        end
      end
    end
  endgenerate

endmodule

// ************************************************************
// transmit path top
// ************************************************************
module ssst_top #(
  parameter FIFO_DEPTH = `SSST_FIFO_DEPTH,
  parameter FIFO_AW = `SSST_FIFO_AW
) (
  // clock and reset
  input wire clock,
  input wire sys_rst,
  // mode configuration
  input wire sync_mode_select,
  input wire clock_source_select,
  input wire single_receive_enable,
  input wire continuous_receive_enable,
  input wire serial_port_enable,
  input wire transmit_enable_bit,
  input wire nine_bit_select,
  input wire ninth_bit_value,
  // interrupt enables and processor state
  input wire peripheral_interrupt_enable,
  input wire tx_interrupt_enable,
  input wire global_interrupt_enable,
  input wire sleep_active,
  // character write port
  input wire wr_valid,
  input wire [7:0] wr_data,
  output wire wr_ready,
  // link pins
  input wire shift_clock_pin_in,
  output reg tx_data_out,
  output reg tx_data_oe,
  // status
  output reg tx_ready_flag,
  output reg shift_busy,
  output reg wake_request,
  output reg interrupt_request
);

  // ************************************************************
  // mode decode
  // ************************************************************
  wire sync_on;
  wire slave_on;
  wire transmit_mode;
  wire port_on;
  wire run;

  assign sync_on = sync_mode_select;
  assign slave_on = ~clock_source_select;
  assign transmit_mode = ~single_receive_enable & ~continuous_receive_enable;
  assign port_on = serial_port_enable;
  // asynchronous and master modes belong to other paths; this one idles
  assign run = sync_on & slave_on & transmit_mode & port_on & transmit_enable_bit;

  // ************************************************************
  // shift clock synchroniser and edge finder
  // ************************************************************
  reg clk_meta_q;
  reg clk_sync_q;
  reg clk_prev_q;
  wire clk_fall;

  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      clk_meta_q <= 1'b0;
      clk_sync_q <= 1'b0;
      clk_prev_q <= 1'b0;
    end
    else
    begin
      clk_meta_q <= shift_clock_pin_in;
      clk_sync_q <= clk_meta_q;
      clk_prev_q <= clk_sync_q;
    end
  end

  // master samples late in the high phase, so the next bit goes out on the fall
  assign clk_fall = clk_prev_q & ~clk_sync_q;

  // ************************************************************
  // character FIFO in front of the holding register
  // ************************************************************
  wire [`SSST_CHAR_W-1:0] wr_char;
  wire [`SSST_CHAR_W-1:0] fifo_char;
  wire fifo_valid;
  wire fifo_take;
  reg hold_full_q;
  reg [`SSST_CHAR_W-1:0] hold_q;

  // ninth bit is caught with the low byte, so it must be set up first
  assign wr_char = {ninth_bit_value & nine_bit_select, wr_data};
  // a disabled port drains nothing: back-pressure reaches the writer
  assign fifo_take = run & ~hold_full_q;

  ssst_fifo #(
    .WIDTH(`SSST_CHAR_W),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clock(clock),
    .sys_rst(sys_rst),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data(wr_char),
    .out_valid(fifo_valid),
    .out_ready(fifo_take),
    .out_data(fifo_char)
  );

  // ************************************************************
  // holding register and shift register
  // ************************************************************
  reg [`SSST_CHAR_W-1:0] tsr_q;
  reg [`SSST_CNT_W-1:0] bits_left_q;
  reg hold_full_d;
  wire start;
  wire last_bit;

  // shifting runs on the master's clock, so sleep does not stop it
  assign start = run & hold_full_q & ~shift_busy;
  assign last_bit = (bits_left_q == 4'h1);

  always @*
  begin
    hold_full_d = hold_full_q;
    if (~run)
    begin
      hold_full_d = 1'b0;
    end
    else if (start)
    begin
      hold_full_d = 1'b0;
    end
    else if (fifo_valid & ~hold_full_q)
    begin
      hold_full_d = 1'b1;
    end
  end

  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      hold_full_q <= 1'b0;
      hold_q <= `SSST_RST_CHAR;
    end
    else
    begin
      hold_full_q <= hold_full_d;
      if (run & fifo_valid & ~hold_full_q)
      begin
        hold_q <= fifo_char;
      end
    end
  end

  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      tsr_q <= `SSST_RST_CHAR;
      bits_left_q <= `SSST_RST_CNT;
      shift_busy <= 1'b0;
      tx_data_out <= `SSST_RST_DATA;
      tx_data_oe <= `SSST_RST_OE;
    end
    else if (~run)
    begin
      // dropping any enable aborts the character under way
      bits_left_q <= `SSST_RST_CNT;
      shift_busy <= 1'b0;
      tx_data_out <= `SSST_RST_DATA;
      tx_data_oe <= 1'b0;
    end
    else
    begin
      tx_data_oe <= 1'b1;
      if (start)
      begin
        tsr_q <= hold_q;
        tx_data_out <= hold_q[0];
        bits_left_q <= nine_bit_select ? `SSST_BITS_9 : `SSST_BITS_8;
        shift_busy <= 1'b1;
      end
      else if (shift_busy & clk_fall)
      begin
        if (last_bit)
        begin
          shift_busy <= 1'b0;
          bits_left_q <= `SSST_RST_CNT;
        end
        else
        begin
          tsr_q <= {1'b0, tsr_q[`SSST_CHAR_W-1:1]};
          tx_data_out <= tsr_q[1];
          bits_left_q <= bits_left_q - 4'h1;
        end
      end
    end
  end

  // ************************************************************
  // ready flag, wake and interrupt
  // ************************************************************
  reg flag_d;

  // flag only rises once nothing waits ahead of the shift register
  always @*
  begin
    flag_d = run & ~hold_full_d & ~fifo_valid;
  end

  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      tx_ready_flag <= `SSST_RST_FLAG;
      wake_request <= 1'b0;
      interrupt_request <= 1'b0;
    end
    else
    begin
      tx_ready_flag <= flag_d;
      wake_request <= sleep_active & flag_d & peripheral_interrupt_enable & tx_interrupt_enable;
      interrupt_request <= flag_d & peripheral_interrupt_enable & tx_interrupt_enable
        & global_interrupt_enable;
    end
  end

endmodule

`default_nettype wire

//--- sim/ssst_chk_assertions.sv
/*
  Port checker for ssst_top.
  Assumes one clock domain; attached by the bind below.
*/
`timescale 1ns/1ns
`default_nettype none
module ssst_chk (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // configuration
  input wire logic sync_mode_select,
  input wire logic clock_source_select,
  input wire logic single_receive_enable,
  input wire logic continuous_receive_enable,
  input wire logic serial_port_enable,
  input wire logic transmit_enable_bit,
  input wire logic peripheral_interrupt_enable,
  input wire logic tx_interrupt_enable,
  input wire logic global_interrupt_enable,
  input wire logic sleep_active,
  // write port and link
  input wire logic wr_valid,
  input wire logic wr_ready,
  input wire logic shift_clock_pin_in,
  input wire logic tx_data_out,
  // output enable and status
  input wire logic tx_data_oe,
  input wire logic tx_ready_flag,
  input wire logic shift_busy,
  input wire logic wake_request,
  input wire logic interrupt_request
);
  logic pin_q;
  logic [3:0] since_q;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // *****
  // age of the last raw pin fall; the design sees it through a synchroniser
  // *****
  always @(posedge clock)
  begin
    pin_q <= shift_clock_pin_in;
    if (sys_rst)
      since_q <= 4'hF;
    else if (pin_q && !shift_clock_pin_in)
      since_q <= 4'h0;
    else if (since_q != 4'hF)
      since_q <= since_q + 4'h1;
  end

  a_async_idle:
    assert property (!sync_mode_select |=> !tx_data_oe && !tx_ready_flag) else $error("active in async");
  a_master_idle:
    assert property (clock_source_select |=> !tx_data_oe && !tx_ready_flag) else $error("active as master");
  a_receive_idle:
    assert property (single_receive_enable || continuous_receive_enable |=> !tx_data_oe) else $error("tx in rx");
  a_port_off:
    assert property (!serial_port_enable |=> !tx_data_oe && !tx_ready_flag) else $error("port off active");
  a_tx_off:
    assert property (!transmit_enable_bit |=> !tx_data_oe && !tx_ready_flag) else $error("tx off active");
  a_bit_step:
    assert property (shift_busy && $past(shift_busy) && $changed(tx_data_out) |-> since_q >= 4'h1 && since_q <= 4'h6)
    else $error("bit moved without fall");
  a_write_clears:
    assert property (wr_valid && wr_ready |-> ##2 !tx_ready_flag) else $error("flag kept after write");
  a_irq_gate:
    assert property (interrupt_request |-> $past(global_interrupt_enable && peripheral_interrupt_enable
      && tx_interrupt_enable)) else $error("irq not enabled");
  a_wake_gate:
    assert property (wake_request |-> $past(sleep_active && peripheral_interrupt_enable && tx_interrupt_enable))
    else $error("wake not enabled");
  c_wake: cover property (wake_request && shift_busy);
  c_irq: cover property (interrupt_request);
  c_full: cover property (!wr_ready);
  c_shift: cover property (shift_busy);
endmodule
bind ssst_top ssst_chk u_chk (.*);
`default_nettype wire

//--- sim/ssst_master.sv
/*
  Model of the external master clocking the slave's data pin.
  Assumes go rises once per character.
*/
`timescale 1ns/1ns
`default_nettype none
module ssst_master (
  // control
  input wire logic go,
  input wire logic slow,
  input wire logic nine,
  // link
  input wire logic din,
  output logic sck,
  // result
  output logic [8:0] got,
  output logic done
);
  initial
  begin
    sck = 1'h0;
    got = 9'h000;
    done = 1'h0;
  end

  // *****
  // clock idles low; sampled late in high phase for margin
  // *****
  always @(posedge go)
  begin
    int half;
    half = slow ? 320 : 160;
    done = 1'h0;
    got = 9'h000;
    for (int i = 0; i < (nine ? 9 : 8); i++)
    begin
      #half sck = 1'h1;
      #half got[i] = din;
      sck = 1'h0;
    end
    #half done = 1'h1;
  end
endmodule
`default_nettype wire

//--- sim/tb_sync_slave_serial_transmit.sv
/*
  Bench for ssst_top: writes, master model, status checks.
  Assumes the checker and master model are compiled with it.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_sync_slave_serial_transmit;
  logic clock, sys_rst, wr_valid, wr_ready, tx_data_out, tx_data_oe;
  logic tx_ready_flag, shift_busy, wake_request, interrupt_request;
  logic shift_clock_pin_in, nine, ninth, sleep, go, slow, done;
  logic [5:0] cfg;
  logic [2:0] ien;
  logic [7:0] wr_data;
  logic [8:0] got;
  int n_errors, n_compared;
  // sync, clock source, two receive enables, port enable, tx enable
  localparam logic [5:0] RUN = 6'h23;

  ssst_top u_dut (
    .sync_mode_select(cfg[5]),
    .clock_source_select(cfg[4]),
    .single_receive_enable(cfg[3]),
    .continuous_receive_enable(cfg[2]),
    .serial_port_enable(cfg[1]),
    .transmit_enable_bit(cfg[0]),
    .nine_bit_select(nine),
    .ninth_bit_value(ninth),
    .global_interrupt_enable(ien[2]),
    .peripheral_interrupt_enable(ien[1]),
    .tx_interrupt_enable(ien[0]),
    .sleep_active(sleep),
    .*
  );
  ssst_master u_mst (
    .go(go),
    .slow(slow),
    .nine(nine),
    // an undriven data pin reads inverted, so a dropped enable mid-frame shows up
    .din(tx_data_oe ? tx_data_out : ~tx_data_out),
    .sck(shift_clock_pin_in),
    .got(got),
    .done(done)
  );

  initial
  begin
    clock = 1'h0;
    forever #20 clock = ~clock;
  end

  // *****
  // tasks
  // *****
  function logic [8:0] st();
    return {2'h0, tx_data_oe, tx_data_out, tx_ready_flag, shift_busy, wake_request, interrupt_request, wr_ready};
  endfunction
  task tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task final_report;
    if (n_errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task give_up;
    n_errors++;
    final_report;
  endtask
  task chk(input logic [8:0] act, input logic [8:0] exp);
    n_compared++;
    if (act !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got=%h exp=%h", $time, act, exp);
    end
  endtask
  // leaves wr_valid high so back-to-back writes never double-drive it
  task wr(input logic [7:0] d);
    int k;
    k = 0;
    wr_data = d;
    wr_valid = 1'h1;
    while (wr_ready !== 1'h1 && k < 400)
    begin
      tick(1);
      k++;
    end
    if (k == 400)
      give_up;
    tick(1);
  endtask
  task sh(input logic [8:0] exp, input logic s);
    int k;
    k = 0;
    slow = s;
    go = 1'h1;
    tick(1);
    go = 1'h0;
    while (done !== 1'h1 && k < 2000)
    begin
      tick(1);
      k++;
    end
    if (k == 2000)
      give_up;
    chk(got, exp);
  endtask

  initial
  begin
    n_errors = 0;
    n_compared = 0;
    sys_rst = 1'h1;
    cfg = RUN;
    {nine, ninth, sleep, go, slow, wr_valid} = 6'h00;
    ien = 3'h0;
    wr_data = 8'h00;
    tick(5);
    chk(st(), 9'h020);
    sys_rst = 1'h0;
    tick(3);
    chk(st(), 9'h071);
    for (int i = 0; i < 6; i++)
    begin
      cfg = RUN ^ (6'h01 << i);
      tick(3);
      chk({7'h00, tx_data_oe, tx_ready_flag}, 9'h000);
    end
    cfg = RUN;
    wr(8'hA5);
    wr_valid = 1'h0;
    tick(4);
    sh(9'h0A5, 1'h0);
    nine = 1'h1;
    ninth = 1'h1;
    wr(8'h3C);
    wr_valid = 1'h0;
    ninth = 1'h0;
    tick(4);
    sh(9'h13C, 1'h1);
    nine = 1'h0;
    ien = 3'h7;
    tick(6);
    chk(st(), 9'h073);
    wr(8'h11);
    wr(8'h22);
    wr_valid = 1'h0;
    sleep = 1'h1;
    tick(4);
    chk(st(), 9'h069);
    sh(9'h011, 1'h0);
    tick(6);
    chk(st(), 9'h05F);
    ien = 3'h3;
    tick(2);
    chk(st(), 9'h05D);
    sh(9'h022, 1'h1);
    sleep = 1'h0;
    ien = 3'h0;
    cfg = RUN ^ 6'h01;
    for (int i = 0; i < 8; i++)
      wr(8'h40 + i[7:0]);
    wr_valid = 1'h0;
    tick(1);
    chk({7'h00, wr_ready, tx_ready_flag}, 9'h000);
    cfg = RUN;
    for (int i = 0; i < 8; i++)
    begin
      tick(4);
      sh({1'h0, 8'h40 + i[7:0]}, i[0]);
    end
    tick(6);
    chk(st(), 9'h051);
    final_report;
  end
endmodule
`default_nettype wire
